// >>> verilog/camds_pkg.sv
// Constants, register map and carrier types of the integer datapath
package camds_pkg;

  // ==========================================================
  // Register byte offsets on the APB
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CORE = 8'h04;
  localparam logic [7:0] OFF_INT_CTL = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0c;
  localparam logic [7:0] OFF_MEM_OPND = 8'h10;
  localparam logic [7:0] OFF_MEM_RES = 8'h14;
  localparam logic [7:0] OFF_BUSY = 8'h18;
  localparam logic [1:0] WREG_PAGE = 2'h1;

  // ==========================================================
  // Field positions
  localparam int ST_C = 0;
  localparam int ST_Z = 1;
  localparam int ST_OVF = 2;
  localparam int ST_N = 3;
  localparam int ST_PRIO_LO = 5;
  localparam int ST_NIB = 8;
  localparam int CC_WIN = 2;
  localparam int CC_MSB = 3;
  localparam int IC_NEST_DIS = 15;

  // ==========================================================
  // Values after reset and counts
  localparam logic [2:0] RST_PRIO = 3'h0;
  localparam logic [15:0] RST_WREG = 16'h0000;
  localparam logic [2:0] PRIO_TOP = 3'h7;
  localparam logic [3:0] DIV_LAST = 4'hf;

  // ==========================================================
  // Operations
  typedef enum logic [4:0] {
    OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
    OP_SRA, OP_SHL, OP_SRL,
    OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_US, OP_MUL_U8,
    OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16
  } camds_op_t;

  // Command word written to OFF_CMD
  typedef struct packed {
    logic [4:0] spare;
    logic lit_sel;
    logic [4:0] literal;
    logic z_sticky;
    logic dst_mem;
    logic src_mem;
    logic [3:0] dst;
    logic [3:0] src_b;
    logic [3:0] src_a;
    logic byte_mode;
    camds_op_t op;
  } camds_cmd_t;

  // Flag carrier
  typedef struct packed {
    logic nib;
    logic n;
    logic ovf;
    logic z;
    logic c;
  } camds_flags_t;

endpackage

// >>> verilog/camds_datapath.sv
// Integer datapath: ALU, multiplier, divider, shifter and core control behind APB
//
// Notes on behaviour
// RULE_01 - Overflow flag set on signed two's complement overflow, cleared otherwise.
// RULE_02 - Negative flag follows the result sign of flag-affecting operations.
// RULE_03 - Priority level is the MSB bit above the 3-bit status priority field.
// RULE_04 - MSB set disables user interrupts; software may clear it; resets to 0.
// RULE_05 - Window enable bit shows program space in data space; read/write, resets 0.
// RULE_06 - 16-bit ALU: add, subtract, shifts, logic; arithmetic is two's complement.
// RULE_07 - ALU updates carry, zero, negative, overflow, nibble carry as the operation dictates.
// RULE_08 - For subtraction carry and nibble carry act as borrow indicators.
// RULE_09 - Instruction mode selects byte-wide or word-wide operation.
// RULE_10 - Operands from working registers or data memory; results to either.
// RULE_11 - 17x17 multiplier: signed, unsigned, mixed 16x16 and unsigned 8x8.
// RULE_12 - Multiplier takes signed or unsigned 16-bit operand times 5-bit literal.
// RULE_13 - Divider: signed and unsigned 32/16 and 16/16 division.
// RULE_14 - Every divide leaves quotient in register 0, remainder in register 1.
// RULE_15 - Divisor from any register; 32-bit dividend from aligned pair, odd upper.
// RULE_16 - Division takes one cycle per divisor bit for both dividend sizes.
// RULE_17 - Shifter does up to 15-bit arithmetic right or left shift in one cycle.
// RULE_18 - Multi-bit shifts read and write working registers only.
// RULE_19 - Arithmetic right uses sign fill; left and logical right use zero fill.
// RULE_20 - Priority field 111 means level 7, or 15 with MSB; user interrupts off.
// RULE_21 - Carry from result MSB; zero flag on zero result, optionally clear-only.
// RULE_22 - Priority field is read-only while nesting disable is set.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module camds_datapath (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt controller side
  input wire logic raise_level_msb,
  output logic [3:0] cpu_priority_level,
  output logic user_irq_disable,
  // Memory system side
  output logic program_space_window_enable,
  output logic busy
);

  typedef enum logic [1:0] {S_IDLE, S_DIV, S_DONE} camds_state_t;

  logic [15:0] wreg_ff [16];
  camds_pkg::camds_flags_t flags_ff;
  logic [2:0] prio_ff;
  logic msb_ff;
  logic win_ff;
  logic nest_dis_ff;
  logic [15:0] mem_opnd_ff;
  logic [15:0] mem_res_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [3:0] level_ff;
  logic irq_dis_ff;
  logic busy_ff;
  camds_state_t state_ff;
  camds_state_t nxt_state;

  // ==========================================================
  // APB decode
  logic apb_setup;
  logic apb_wr;
  logic wr_status, wr_core, wr_int_ctl, wr_cmd, wr_mem, wr_wreg;
  logic addr_hit;
  logic [31:0] rd_val;
  logic [15:0] status_rd;
  logic [15:0] core_rd;

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite && pready_ff;

  always_comb begin
    status_rd = 16'h0000;
    status_rd[camds_pkg::ST_C] = flags_ff.c;
    status_rd[camds_pkg::ST_Z] = flags_ff.z;
    status_rd[camds_pkg::ST_OVF] = flags_ff.ovf;
    status_rd[camds_pkg::ST_N] = flags_ff.n;
    status_rd[camds_pkg::ST_PRIO_LO +: 3] = prio_ff;
    status_rd[camds_pkg::ST_NIB] = flags_ff.nib;
    core_rd = 16'h0000;
    core_rd[camds_pkg::CC_MSB] = msb_ff;
    core_rd[camds_pkg::CC_WIN] = win_ff;
  end

  always_comb begin
    addr_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr == camds_pkg::OFF_STATUS) begin
      rd_val = {16'h0000, status_rd};
    end else if (paddr == camds_pkg::OFF_CORE) begin
      rd_val = {16'h0000, core_rd};
    end else if (paddr == camds_pkg::OFF_INT_CTL) begin
      rd_val[camds_pkg::IC_NEST_DIS] = nest_dis_ff;
    end else if (paddr == camds_pkg::OFF_CMD) begin
      rd_val = 32'h0000_0000;
    end else if (paddr == camds_pkg::OFF_MEM_OPND) begin
      rd_val = {16'h0000, mem_opnd_ff};
    end else if (paddr == camds_pkg::OFF_MEM_RES) begin
      rd_val = {16'h0000, mem_res_ff};
    end else if (paddr == camds_pkg::OFF_BUSY) begin
      rd_val = {31'h0000_0000, busy_ff};
    end else if (paddr[7:6] == camds_pkg::WREG_PAGE && paddr[1:0] == 2'h0) begin
      rd_val = {16'h0000, wreg_ff[paddr[5:2]]};
    end else begin
      addr_hit = 1'b0;
    end
  end

  assign wr_status = apb_wr && paddr == camds_pkg::OFF_STATUS;
  assign wr_core = apb_wr && paddr == camds_pkg::OFF_CORE;
  assign wr_int_ctl = apb_wr && paddr == camds_pkg::OFF_INT_CTL;
  assign wr_cmd = apb_wr && paddr == camds_pkg::OFF_CMD;
  assign wr_mem = apb_wr && paddr == camds_pkg::OFF_MEM_OPND;
  assign wr_wreg = apb_wr && paddr[7:6] == camds_pkg::WREG_PAGE && paddr[1:0] == 2'h0;

  // Zero wait states: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= apb_setup;
      pslverr_ff <= apb_setup && !addr_hit;
      if (apb_setup) begin
        prdata_ff <= rd_val;
      end
    end
  end

  // ==========================================================
  // Operand selection and ALU
  camds_pkg::camds_cmd_t cmd;
  logic cmd_go, is_div, is_shift, alu_go, div_go;
  logic [15:0] opa, opb, b_eff, raw, res_w, res_m;
  logic [16:0] sum17;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic cin, upd_cdo, upd_nz, wr_one, wr_two;
  logic msb_a, msb_b, msb_r, f_zero;
  camds_pkg::camds_flags_t f_new;

  assign cmd = camds_pkg::camds_cmd_t'(pwdata);
  // Commands written while a divide runs are dropped
  assign cmd_go = wr_cmd && state_ff == S_IDLE;
  assign is_div = cmd.op inside {camds_pkg::OP_DIV_S32, camds_pkg::OP_DIV_U32,
                                 camds_pkg::OP_DIV_S16, camds_pkg::OP_DIV_U16};
  assign is_shift = cmd.op inside {camds_pkg::OP_SRA, camds_pkg::OP_SHL, camds_pkg::OP_SRL};
  assign alu_go = cmd_go && !is_div;
  assign div_go = cmd_go && is_div;

  assign opa = (cmd.src_mem && !is_shift) ? mem_opnd_ff : wreg_ff[cmd.src_a]; // RULE_10 RULE_18
  assign opb = cmd.lit_sel ? {11'h000, cmd.literal} : wreg_ff[cmd.src_b]; // RULE_12

  // Multiplier, 17x17 signed core
  logic signed [16:0] ma, mb;
  logic signed [33:0] prod;
  always_comb begin
    ma = {cmd.op inside {camds_pkg::OP_MUL_SS, camds_pkg::OP_MUL_SU} && opa[15], opa}; // RULE_11
    mb = {cmd.op inside {camds_pkg::OP_MUL_SS, camds_pkg::OP_MUL_US} && opb[15], opb};
    if (cmd.op == camds_pkg::OP_MUL_U8) begin
      ma = {9'h000, opa[7:0]};
      mb = {9'h000, opb[7:0]};
    end
    prod = ma * mb; // RULE_11 RULE_12
  end

  always_comb begin
    cin = cmd.op == camds_pkg::OP_SUB;
    // Subtract as a + ~b + 1, so carry high means no borrow
    b_eff = cin ? ~opb : opb; // RULE_08
    sum17 = {1'b0, opa} + {1'b0, b_eff} + {16'h0000, cin}; // RULE_06
    sum9 = {1'b0, opa[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
    nib5 = {1'b0, opa[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    raw = 16'h0000;
    upd_cdo = 1'b0;
    upd_nz = 1'b0;
    wr_one = 1'b0;
    wr_two = 1'b0;
    case (cmd.op)
      camds_pkg::OP_ADD, camds_pkg::OP_SUB: begin
        raw = sum17[15:0];
        upd_cdo = 1'b1;
        upd_nz = 1'b1;
        wr_one = 1'b1;
      end
      camds_pkg::OP_AND, camds_pkg::OP_IOR, camds_pkg::OP_XOR: begin
        if (cmd.op == camds_pkg::OP_AND) begin
          raw = opa & opb;
        end else if (cmd.op == camds_pkg::OP_IOR) begin
          raw = opa | opb;
        end else begin
          raw = opa ^ opb;
        end
        upd_nz = 1'b1;
        wr_one = 1'b1;
      end
      camds_pkg::OP_SRA: begin
        raw = 16'($signed(opa) >>> opb[3:0]); // RULE_17 RULE_19
        upd_nz = 1'b1;
        wr_one = 1'b1;
      end
      camds_pkg::OP_SHL: begin
        raw = opa << opb[3:0]; // RULE_17 RULE_19
        upd_nz = 1'b1;
        wr_one = 1'b1;
      end
      camds_pkg::OP_SRL: begin
        raw = opa >> opb[3:0]; // RULE_19
        upd_nz = 1'b1;
        wr_one = 1'b1;
      end
      camds_pkg::OP_MUL_U8: begin
        raw = prod[15:0];
        wr_one = 1'b1;
      end
      camds_pkg::OP_MUL_SS, camds_pkg::OP_MUL_UU, camds_pkg::OP_MUL_SU,
      camds_pkg::OP_MUL_US: begin
        wr_two = 1'b1;
      end
      default: begin
      end
    endcase
    // Byte mode keeps the destination's upper byte
    if (cmd.byte_mode && cmd.op != camds_pkg::OP_MUL_U8) begin // RULE_09
      res_w = {wreg_ff[cmd.dst][15:8], raw[7:0]};
      res_m = {mem_res_ff[15:8], raw[7:0]};
      msb_a = opa[7];
      msb_b = b_eff[7];
      msb_r = raw[7];
      f_zero = raw[7:0] == 8'h00;
      f_new.c = sum9[8];
      f_new.nib = nib5[4];
    end else begin
      res_w = raw;
      res_m = raw;
      msb_a = opa[15];
      msb_b = b_eff[15];
      msb_r = raw[15];
      f_zero = raw == 16'h0000;
      f_new.c = sum17[16]; // RULE_21
      f_new.nib = sum9[8];
    end
    f_new.ovf = (msb_a == msb_b) && (msb_r != msb_a); // RULE_01
    f_new.n = msb_r; // RULE_02
    f_new.z = cmd.z_sticky ? (flags_ff.z && f_zero) : f_zero; // RULE_21
  end

  // ==========================================================
  // Divider: restoring, one quotient bit per cycle
  logic dvd_signed, dvd_neg, dvs_neg;
  logic [31:0] dvd_raw, dvd_abs;
  logic [15:0] dvs_raw, dvs_abs;
  logic [16:0] div_rem_ff, shifted, nxt_rem;
  logic [17:0] diff;
  logic [15:0] div_quo_ff, div_dvs_ff, nxt_quo, fin_q, fin_r;
  logic [3:0] div_cnt_ff;
  logic neg_q_ff, neg_r_ff, div_ovf_ff;

  always_comb begin
    dvd_signed = cmd.op inside {camds_pkg::OP_DIV_S32, camds_pkg::OP_DIV_S16};
    if (cmd.op inside {camds_pkg::OP_DIV_S32, camds_pkg::OP_DIV_U32}) begin
      dvd_raw = {wreg_ff[{cmd.src_a[3:1], 1'b1}], wreg_ff[{cmd.src_a[3:1], 1'b0}]}; // RULE_15
    end else if (dvd_signed) begin
      dvd_raw = {{16{wreg_ff[cmd.src_a][15]}}, wreg_ff[cmd.src_a]};
    end else begin
      dvd_raw = {16'h0000, wreg_ff[cmd.src_a]};
    end
    dvs_raw = wreg_ff[cmd.src_b]; // RULE_15
    dvd_neg = dvd_signed && dvd_raw[31];
    dvs_neg = dvd_signed && dvs_raw[15];
    dvd_abs = dvd_neg ? -dvd_raw : dvd_raw; // RULE_13
    dvs_abs = dvs_neg ? -dvs_raw : dvs_raw;
    shifted = {div_rem_ff[15:0], div_quo_ff[15]};
    diff = {1'b0, shifted} - {2'b00, div_dvs_ff};
    nxt_rem = diff[17] ? shifted : diff[16:0];
    nxt_quo = {div_quo_ff[14:0], !diff[17]};
    fin_q = neg_q_ff ? -div_quo_ff : div_quo_ff;
    fin_r = neg_r_ff ? -div_rem_ff[15:0] : div_rem_ff[15:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_rem_ff <= 17'h0_0000;
      div_quo_ff <= 16'h0000;
      div_dvs_ff <= 16'h0000;
      div_cnt_ff <= 4'h0;
      neg_q_ff <= 1'b0;
      neg_r_ff <= 1'b0;
      div_ovf_ff <= 1'b0;
    end else if (div_go) begin
      div_rem_ff <= {1'b0, dvd_abs[31:16]};
      div_quo_ff <= dvd_abs[15:0];
      div_dvs_ff <= dvs_abs;
      div_cnt_ff <= 4'h0;
      neg_q_ff <= dvd_neg ^ dvs_neg;
      neg_r_ff <= dvd_neg;
      // Quotient cannot fit, or divide by zero
      div_ovf_ff <= dvd_abs[31:16] >= dvs_abs;
    end else if (state_ff == S_DIV) begin
      div_rem_ff <= nxt_rem;
      div_quo_ff <= nxt_quo;
      div_cnt_ff <= div_cnt_ff + 4'h1; // RULE_16
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (div_go) begin
          nxt_state = S_DIV;
        end
      end
      S_DIV: begin
        if (div_cnt_ff == camds_pkg::DIV_LAST) begin // RULE_16
          nxt_state = S_DONE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= S_IDLE;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= nxt_state != S_IDLE;
    end
  end

  // ==========================================================
  // Working registers and memory result
  for (genvar i = 0; i < 16; i++) begin : g_wreg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        wreg_ff[i] <= camds_pkg::RST_WREG;
      end else if (state_ff == S_DONE && i == 0) begin
        wreg_ff[i] <= fin_q; // RULE_14
      end else if (state_ff == S_DONE && i == 1) begin
        wreg_ff[i] <= fin_r; // RULE_14
      end else if (alu_go && wr_two && {cmd.dst[3:1], 1'b0} == 4'(i)) begin
        wreg_ff[i] <= prod[15:0];
      end else if (alu_go && wr_two && {cmd.dst[3:1], 1'b1} == 4'(i)) begin
        wreg_ff[i] <= prod[31:16];
      end else if (alu_go && wr_one && (!cmd.dst_mem || is_shift) && cmd.dst == 4'(i)) begin
        wreg_ff[i] <= res_w; // RULE_10 RULE_18
      end else if (wr_wreg && paddr[5:2] == 4'(i)) begin
        wreg_ff[i] <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_opnd_ff <= 16'h0000;
      mem_res_ff <= 16'h0000;
    end else begin
      if (wr_mem) begin
        mem_opnd_ff <= pwdata[15:0];
      end
      if (alu_go && wr_one && cmd.dst_mem && !is_shift) begin
        mem_res_ff <= res_m; // RULE_10
      end
    end
  end

  // ==========================================================
  // Status flags and priority field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= '0;
      prio_ff <= camds_pkg::RST_PRIO;
    end else if (state_ff == S_DONE) begin
      // Divide completion wins over a software write in the same cycle
      flags_ff.n <= fin_q[15];
      flags_ff.z <= fin_q == 16'h0000;
      flags_ff.ovf <= div_ovf_ff;
    end else if (alu_go) begin
      if (upd_cdo) begin
        flags_ff.c <= f_new.c; // RULE_07 RULE_08
        flags_ff.nib <= f_new.nib; // RULE_07
        flags_ff.ovf <= f_new.ovf; // RULE_01
      end
      if (upd_nz) begin
        flags_ff.n <= f_new.n; // RULE_02
        flags_ff.z <= f_new.z; // RULE_21
      end
    end else if (wr_status) begin
      flags_ff.c <= pwdata[camds_pkg::ST_C];
      flags_ff.z <= pwdata[camds_pkg::ST_Z];
      flags_ff.ovf <= pwdata[camds_pkg::ST_OVF];
      flags_ff.n <= pwdata[camds_pkg::ST_N];
      flags_ff.nib <= pwdata[camds_pkg::ST_NIB];
      if (!nest_dis_ff) begin
        prio_ff <= pwdata[camds_pkg::ST_PRIO_LO +: 3]; // RULE_22
      end
    end
  end

  // ==========================================================
  // Core control and interrupt control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msb_ff <= 1'b0;
      win_ff <= 1'b0;
      nest_dis_ff <= 1'b0;
    end else begin
      // Raise wins over a software clear in the same cycle
      if (raise_level_msb) begin
        msb_ff <= 1'b1;
      end else if (wr_core && !pwdata[camds_pkg::CC_MSB]) begin
        msb_ff <= 1'b0; // RULE_04
      end
      if (wr_core) begin
        win_ff <= pwdata[camds_pkg::CC_WIN]; // RULE_05
      end
      if (wr_int_ctl) begin
        nest_dis_ff <= pwdata[camds_pkg::IC_NEST_DIS];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_ff <= 4'h0;
      irq_dis_ff <= 1'b0;
    end else begin
      level_ff <= {msb_ff, prio_ff}; // RULE_03
      irq_dis_ff <= msb_ff || prio_ff == camds_pkg::PRIO_TOP; // RULE_04 RULE_20
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cpu_priority_level = level_ff;
  assign user_irq_disable = irq_dis_ff;
  assign program_space_window_enable = win_ff;
  assign busy = busy_ff;

  // ==========================================================
  // Assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_answer_a: assert property (apb_setup |=> pready_ff ##1 !pready_ff)
    else $error("APB answer not in first access cycle");
  level_concat_a: assert property (##1 level_ff == $past({msb_ff, prio_ff})) // RULE_03
    else $error("Priority level not MSB over field");
  msb_disable_a: assert property (msb_ff |=> irq_dis_ff) // RULE_04
    else $error("User interrupts not disabled with MSB set");
  level_seven_a: assert property ( // RULE_20
      prio_ff == 3'h7 |=> irq_dis_ff && level_ff[2:0] == 3'h7)
    else $error("Level seven not reported");
  window_follow_a: assert property (wr_core |=> win_ff == $past(pwdata[2])) // RULE_05
    else $error("Window enable did not follow write");
  field_locked_a: assert property ( // RULE_22
      wr_status && nest_dis_ff |=> prio_ff == $past(prio_ff))
    else $error("Priority field changed while locked");
  div_length_a: assert property (div_go |-> ##17 state_ff == S_DONE ##1 !busy_ff) // RULE_16
    else $error("Divide did not take sixteen steps");
  div_result_a: assert property (state_ff == S_DONE |=> // RULE_14
      wreg_ff[0] == $past(fin_q) && wreg_ff[1] == $past(fin_r))
    else $error("Quotient or remainder misplaced");
  add_overflow_a: assert property ( // RULE_01
      alu_go && cmd.op == camds_pkg::OP_ADD && !cmd.byte_mode |=>
      flags_ff.ovf == ($past(opa[15]) == $past(opb[15]) && $past(sum17[15]) != $past(opa[15])))
    else $error("Overflow flag wrong after add");
  neg_flag_a: assert property ( // RULE_02
      alu_go && upd_nz && !cmd.byte_mode |=> flags_ff.n == $past(raw[15]))
    else $error("Negative flag wrong");
  sra_shift_a: assert property ( // RULE_17
      alu_go && cmd.op == camds_pkg::OP_SRA && !cmd.byte_mode |=>
      wreg_ff[$past(cmd.dst)] == 16'($signed($past(opa)) >>> $past(opb[3:0])))
    else $error("Arithmetic right shift wrong");

  div_done_c: cover property (div_go ##17 state_ff == S_DONE);
  msb_raise_c: cover property (raise_level_msb ##1 irq_dis_ff);
  sub_borrow_c: cover property (alu_go && cmd.op == camds_pkg::OP_SUB && !f_new.c);
  mul_pair_c: cover property (alu_go && wr_two);

endmodule

// >>> tb/camds_irq_model.sv
// Interrupt controller stand-in that raises the priority level MSB
`timescale 1ns/1ps
module camds_irq_model (
  // Clock
  input wire logic pclk,
  // Level request
  output logic raise_level_msb
);
  initial raise_level_msb = 1'b0;
  // ==========================================
  // One-cycle request, launched after an edge
  task automatic raise();
    @(posedge pclk);
    raise_level_msb <= 1'b1;
    @(posedge pclk);
    raise_level_msb <= 1'b0;
  endtask
endmodule

// >>> tb/cpu_alu_mul_div_shift_test.sv
// Self-checking bench for the integer datapath
`timescale 1ns/1ps
module cpu_alu_mul_div_shift_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic raise_level_msb;
  logic [3:0] cpu_priority_level;
  logic user_irq_disable;
  logic program_space_window_enable;
  logic busy;
  logic [31:0] rdat;
  logic rerr;
  int miscompares = 0;
  int compares = 0;
  int n;
  camds_pkg::camds_op_t sops[6] = '{camds_pkg::OP_SRA, camds_pkg::OP_SHL, camds_pkg::OP_SRL,
    camds_pkg::OP_AND, camds_pkg::OP_IOR, camds_pkg::OP_XOR};
  logic [31:0] sexp[6] = '{32'hffff, 32'h8000, 32'h0001, 32'h0001, 32'h800f, 32'h800e};
  camds_pkg::camds_op_t dops[4] = '{camds_pkg::OP_DIV_U16, camds_pkg::OP_DIV_U32,
    camds_pkg::OP_DIV_S32, camds_pkg::OP_DIV_S16};
  logic [3:0] dsrc[4] = '{4'h9, 4'h0, 4'ha, 4'h6};
  logic [31:0] dq[4] = '{32'h000e, 32'h4926, 32'hfff2, 32'hedbc};
  logic [31:0] dr[4] = '{32'h0002, 32'h0004, 32'hfffe, 32'hfffb};

  always #25 pclk = ~pclk;

  camds_datapath dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .raise_level_msb(raise_level_msb),
    .cpu_priority_level(cpu_priority_level), .user_irq_disable(user_irq_disable),
    .program_space_window_enable(program_space_window_enable), .busy(busy));
  camds_irq_model irq (.pclk(pclk), .raise_level_msb(raise_level_msb));

  // ==========================================
  // Reporting
  task automatic results();
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ==========================================
  // APB master; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k == 20) begin
      miscompares++;
      results();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge keeps back-to-back calls from driving psel twice at once
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  function automatic logic [7:0] wa(input logic [3:0] i);
    return {2'b01, i, 2'b00};
  endfunction
  function automatic logic [31:0] cmd(input camds_pkg::camds_op_t op, input logic bm,
      input logic [3:0] a, input logic [3:0] b, input logic [3:0] d, input logic zs,
      input logic ls, input logic [4:0] lv);
    camds_pkg::camds_cmd_t c;
    c = '0;
    c.op = op;
    c.byte_mode = bm;
    c.src_a = a;
    c.src_b = b;
    c.dst = d;
    c.z_sticky = zs;
    c.lit_sel = ls;
    c.literal = lv;
    return c;
  endfunction

  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(camds_pkg::OFF_STATUS, 32'h0);
    rdchk(camds_pkg::OFF_CORE, 32'h0);
    chk({28'h0, cpu_priority_level}, 32'h0);
    xfer(1'b1, camds_pkg::OFF_CORE, 32'h4);
    rdchk(camds_pkg::OFF_CORE, 32'h4);
    chk({31'h0, program_space_window_enable}, 32'h1);
    rdchk(8'h30, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    xfer(1'b1, wa(4'h1), 32'h7fff);
    xfer(1'b1, wa(4'h2), 32'h0001);
    xfer(1'b1, camds_pkg::OFF_CMD, cmd(camds_pkg::OP_ADD, 0, 1, 2, 3, 0, 0, 0));
    rdchk(wa(4'h3), 32'h8000);
    rdchk(camds_pkg::OFF_STATUS, 32'h10c);
    // Sticky zero may only clear, so a zero result leaves it low
    xfer(1'b1, camds_pkg::OFF_CMD, cmd(camds_pkg::OP_SUB, 0, 2, 2, 3, 1, 0, 0));
    rdchk(camds_pkg::OFF_STATUS, 32'h101);
    xfer(1'b1, camds_pkg::OFF_CMD, cmd(camds_pkg::OP_SUB, 0, 2, 2, 3, 0, 0, 0));
    rdchk(camds_pkg::OFF_STATUS, 32'h103);
    xfer(1'b1, wa(4'h3), 32'h1234);
    xfer(1'b1, camds_pkg::OFF_CMD, cmd(camds_pkg::OP_ADD, 1, 1, 2, 3, 0, 0, 0));
    rdchk(wa(4'h3), 32'h1200);
    rdchk(camds_pkg::OFF_STATUS, 32'h103);
    xfer(1'b1, wa(4'h4), 32'h8001);
    foreach (sops[i]) begin
      xfer(1'b1, camds_pkg::OFF_CMD, cmd(sops[i], 0, 4, 0, 5, 0, 1, 5'h0f));
      rdchk(wa(4'h5), sexp[i]);
    end
    xfer(1'b1, camds_pkg::OFF_CMD, cmd(camds_pkg::OP_MUL_SU, 0, 4, 0, 6, 0, 1, 5'h1f));
    rdchk(wa(4'h6), 32'h801f);
    rdchk(wa(4'h7), 32'hfff0);
    xfer(1'b1, camds_pkg::OFF_CMD, cmd(camds_pkg::OP_MUL_UU, 0, 4, 4, 12, 0, 0, 0));
    rdchk(wa(4'hd), 32'h4001);
    xfer(1'b1, camds_pkg::OFF_CMD, cmd(camds_pkg::OP_MUL_SS, 0, 4, 4, 12, 0, 0, 0));
    rdchk(wa(4'hd), 32'h3fff);
    // Memory operand in, memory result out, no register touched
    xfer(1'b1, camds_pkg::OFF_MEM_OPND, 32'hf3);
    xfer(1'b1, camds_pkg::OFF_CMD,
      cmd(camds_pkg::OP_MUL_U8, 0, 0, 0, 0, 0, 1, 5'h11) | 32'h000c_0000);
    rdchk(camds_pkg::OFF_MEM_RES, 32'h1023);
    rdchk(wa(4'h0), 32'h0);
    xfer(1'b1, wa(4'h8), 32'h0007);
    xfer(1'b1, wa(4'h9), 32'h0064);
    xfer(1'b1, wa(4'ha), 32'hff9c);
    xfer(1'b1, wa(4'hb), 32'hffff);
    foreach (dops[i]) begin
      xfer(1'b1, camds_pkg::OFF_CMD, cmd(dops[i], 0, dsrc[i], 8, 0, 0, 0, 0));
      n = 0;
      while (busy === 1'b1 && n < 40) begin
        @(posedge pclk);
        n++;
      end
      chk(n, 32'd17);
      rdchk(wa(4'h0), dq[i]);
      rdchk(wa(4'h1), dr[i]);
    end
    xfer(1'b1, camds_pkg::OFF_STATUS, 32'he0);
    // Level outputs lag the field by one more edge
    @(posedge pclk);
    chk({31'h0, user_irq_disable}, 32'h1);
    chk({28'h0, cpu_priority_level}, 32'h7);
    xfer(1'b1, camds_pkg::OFF_INT_CTL, 32'h8000);
    xfer(1'b1, camds_pkg::OFF_STATUS, 32'h0);
    rdchk(camds_pkg::OFF_STATUS, 32'he0);
    irq.raise();
    repeat (2) @(posedge pclk);
    rdchk(camds_pkg::OFF_CORE, 32'hc);
    chk({28'h0, cpu_priority_level}, 32'hf);
    xfer(1'b1, camds_pkg::OFF_CORE, 32'h4);
    rdchk(camds_pkg::OFF_CORE, 32'h4);
    xfer(1'b1, camds_pkg::OFF_CORE, 32'hc);
    rdchk(camds_pkg::OFF_CORE, 32'h4);
    results();
  end
endmodule
